// >>> phyx_buf2.sv
// Two-entry valid/ready buffer for transmit nibbles
`timescale 1ns/1ps
module phyx_buf2 (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input phyx_pkg::phyx_nib_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output phyx_pkg::phyx_nib_t out_data
);

	// ==========================================================
	// Storage and pointers
	// ==========================================================
	phyx_pkg::phyx_nib_t mem_reg [2]; // Two slots
	logic wr_ptr_reg; // Next slot to fill
	logic rd_ptr_reg; // Oldest slot
	logic [1:0] cnt_reg; // Words held
	logic ready_reg; // Room for one more
	logic push; // Word taken in
	logic pop; // Word handed out
	logic [1:0] cnt_next;

	assign push = in_valid & ready_reg;
	assign pop = out_valid & out_ready;
	assign cnt_next = cnt_reg + (push ? phyx_pkg::BUF_ONE : 2'h0) - (pop ? phyx_pkg::BUF_ONE : 2'h0);
	assign in_ready = ready_reg;
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];

	// Ready is registered so the source sees a flop, full stalls it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= 1'h0;
			rd_ptr_reg <= 1'h0;
			cnt_reg <= 2'h0;
			ready_reg <= 1'h1;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			cnt_reg <= cnt_next;
			ready_reg <= (cnt_next != phyx_pkg::BUF_DEPTH);
		end
	end

	// Data slots need no reset, valid guards them
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

endmodule // phyx_buf2

// >>> phyx_enc45.sv
// Nibble to five-bit symbol translation, normal and invalid-code test
`timescale 1ns/1ps
module phyx_enc45 (
	input phyx_pkg::phyx_nib_t nib_in,
	input wire logic inv_mode,
	output logic [4:0] sym_out
);

	// ==========================================================
	// Standard data code groups
	// ==========================================================
	function automatic logic [4:0] std_code(input logic [3:0] n);
		logic [4:0] s;
		s = 5'h00;
		case (n)
			4'h0: s = 5'h1E;
			4'h1: s = 5'h09;
			4'h2: s = 5'h14;
			4'h3: s = 5'h15;
			4'h4: s = 5'h0A;
			4'h5: s = 5'h0B;
			4'h6: s = 5'h0E;
			4'h7: s = 5'h0F;
			4'h8: s = 5'h12;
			4'h9: s = 5'h13;
			4'hA: s = 5'h16;
			4'hB: s = 5'h17;
			4'hC: s = 5'h1A;
			4'hD: s = 5'h1B;
			4'hE: s = 5'h1C;
			default: s = 5'h1D;
		endcase
		return s;
	endfunction

	// ==========================================================
	// Test translation, raw bit patterns on the line
	// ==========================================================
	function automatic logic [4:0] test_code(input logic [3:0] n);
		logic [4:0] s;
		s = 5'h00;
		case (n)
			4'h8: s = 5'h00;
			4'h9: s = 5'h0D;
			4'hA: s = 5'h0C;
			4'hB: s = 5'h11;
			4'hC: s = 5'h10;
			4'hD: s = 5'h19;
			4'hE: s = 5'h18;
			4'hF: s = 5'h1F;
			default: s = {1'h0, n};
		endcase
		return s;
	endfunction

	logic test_sel; // Test table chosen
	logic [4:0] normal_sym; // Standard path symbol

	// Error without test mode sends the standard halt code
	assign normal_sym = nib_in.err ? 5'h04 : std_code(nib_in.nib);
	assign test_sel = inv_mode & nib_in.err;
	assign sym_out = test_sel ? test_code(nib_in.nib) : normal_sym;

endmodule // phyx_enc45

// >>> phyx_ext_ctrl.sv
// Extended control register with its transmit and receive stream controls
//
// Overview of operation
// - Override-write enable clears after next management write
// - Reserved bits 14:11, 4, 1 read zero
// - Bits 10:6 hold strap-captured management address
// - Soft reset keeps the latched address
// - Scrambler test mode drops receive lock
// - Encoding bit picks NRZ or NRZI at 100 megabit; 10 megabit is always NRZ
// - Invalid-code bit clear keeps standard translation
// - Test nibbles 0-7 get leading zero; 8 zero
// - Test nibbles 9-F use fixed symbol table
// - Cipher disable bypasses scrambler and descrambler
// - Cipher works only at 100 megabit
`timescale 1ns/1ps
module phyx_ext_ctrl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic addr4_strap_pin,
	input wire logic addr3_strap_pin,
	input wire logic addr2_strap_pin,
	input wire logic addr1_strap_pin,
	input wire logic addr0_strap_pin,
	input wire logic mgmt_wr_en,
	input wire logic mgmt_rd_en,
	input wire logic [4:0] mgmt_reg_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rdata_valid,
	output logic override_protected_bit_unlock,
	output logic [4:0] phy_addr,
	input wire logic rate_100,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [3:0] tx_nib,
	input wire logic tx_er,
	output logic tx_sym_valid,
	input wire logic tx_sym_ready,
	output logic [4:0] tx_sym,
	input wire logic rx_sym_in_valid,
	input wire logic [4:0] rx_sym_in,
	output logic rx_sym_valid,
	output logic [4:0] rx_sym,
	output logic rx_locked
);

	// ==========================================================
	// Control register state
	// ==========================================================
	logic ovr_reg; // Override-write enable
	logic test_reg; // Scrambler test mode
	logic nrzi_reg; // 1 selects NRZI
	logic inv_reg; // Invalid-code test
	logic cdis_reg; // Cipher disable
	logic [4:0] addr_reg; // Captured management address
	phyx_pkg::phyx_strap_t strap_reg; // Strap capture progress
	logic [15:0] rdata_reg; // Read data holding
	logic rvalid_reg; // Read answer strobe

	// ==========================================================
	// Management decode
	// ==========================================================
	logic hit; // Access aims at this register
	logic wr_hit; // Write to this register
	logic rd_hit; // Read of this register
	logic [15:0] rd_word; // Assembled read value
	logic ovr_next;

	assign hit = (mgmt_reg_addr == phyx_pkg::EXT_CTRL_ADDR);
	assign wr_hit = mgmt_wr_en & hit;
	assign rd_hit = mgmt_rd_en & hit;

	// Any write consumes the unlock; only a write here with bit 15 set re-arms it
	assign ovr_next = mgmt_wr_en ? (wr_hit & mgmt_wdata[phyx_pkg::OVR_BIT]) : ovr_reg;

	// Reserved positions are constant zero, nothing stored there
	assign rd_word = {ovr_reg, 4'h0, addr_reg, test_reg, 1'h0, nrzi_reg, inv_reg, 1'h0,
		cdis_reg};

	// Outputs straight from flops
	assign mgmt_rdata = rdata_reg;
	assign mgmt_rdata_valid = rvalid_reg;
	assign override_protected_bit_unlock = ovr_reg;
	assign phy_addr = addr_reg;

	// Writable control bits; soft reset restores their defaults.
	// Reserved write data is dropped, the manager keeps it at default.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ovr_reg <= phyx_pkg::OVR_RST;
			test_reg <= phyx_pkg::TEST_RST;
			nrzi_reg <= phyx_pkg::NRZI_RST;
			inv_reg <= phyx_pkg::INV_RST;
			cdis_reg <= phyx_pkg::CDIS_RST;
		end else if (soft_reset) begin
			ovr_reg <= phyx_pkg::OVR_RST;
			test_reg <= phyx_pkg::TEST_RST;
			nrzi_reg <= phyx_pkg::NRZI_RST;
			inv_reg <= phyx_pkg::INV_RST;
			cdis_reg <= phyx_pkg::CDIS_RST;
		end else begin
			ovr_reg <= ovr_next;
			// Held until rewritten, no self clearing here
			if (wr_hit) begin
				test_reg <= mgmt_wdata[phyx_pkg::TEST_BIT];
				nrzi_reg <= mgmt_wdata[phyx_pkg::NRZI_BIT];
				inv_reg <= mgmt_wdata[phyx_pkg::INV_BIT];
				cdis_reg <= mgmt_wdata[phyx_pkg::CDIS_BIT];
			end
		end
	end

	// Strap capture on the first edge after hardware reset release.
	// The pins are not loaded under reset itself, and soft reset
	// leaves this process alone so the address survives it.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			strap_reg <= phyx_pkg::STRAP_WAIT;
			addr_reg <= phyx_pkg::ADDR_RST;
		end else begin
			unique case (strap_reg)
				phyx_pkg::STRAP_WAIT: begin
					addr_reg <= {addr4_strap_pin, addr3_strap_pin, addr2_strap_pin,
						addr1_strap_pin, addr0_strap_pin};
					strap_reg <= phyx_pkg::STRAP_DONE;
				end
				phyx_pkg::STRAP_DONE: begin
					addr_reg <= addr_reg;
				end
			endcase
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_reg <= phyx_pkg::RDATA_RST;
			rvalid_reg <= 1'h0;
		end else begin
			rvalid_reg <= rd_hit;
			if (rd_hit) begin
				rdata_reg <= rd_word;
			end
		end
	end

	// ==========================================================
	// Cipher helpers
	// ==========================================================
	// Scramble five bits, MSB first; returns {new state, data}
	function automatic logic [15:0] scramble(input logic [10:0] st, input logic [4:0] d);
		logic [10:0] l;
		logic [4:0] o;
		logic k;
		l = st;
		o = 5'h00;
		k = 1'h0;
		for (int i = 4; i >= 0; i--) begin
			k = l[phyx_pkg::LFSR_TAP_A] ^ l[phyx_pkg::LFSR_TAP_B];
			o[i] = d[i] ^ k;
			l = {l[9:0], k};
		end
		return {l, o};
	endfunction

	// Descramble five bits; also reports if the keystream disagreed
	// with an idle pattern, and trains the state while unlocked.
	function automatic logic [16:0] descramble(input logic [10:0] st, input logic [4:0] d,
		input logic train);
		logic [10:0] l;
		logic [4:0] o;
		logic k;
		logic miss;
		l = st;
		o = 5'h00;
		k = 1'h0;
		miss = 1'h0;
		for (int i = 4; i >= 0; i--) begin
			k = l[phyx_pkg::LFSR_TAP_A] ^ l[phyx_pkg::LFSR_TAP_B];
			// Idle is all ones, so the key is the inverted line bit
			miss = miss | (k != ~d[i]);
			o[i] = d[i] ^ k;
			l = {l[9:0], train ? ~d[i] : k};
		end
		return {miss, l, o};
	endfunction

	// NRZI: a one toggles the line level; returns {last level, bits}
	function automatic logic [5:0] nrzi_code(input logic lvl_in, input logic [4:0] d);
		logic lvl;
		logic [4:0] o;
		lvl = lvl_in;
		o = 5'h00;
		for (int i = 4; i >= 0; i--) begin
			lvl = lvl ^ d[i];
			o[i] = lvl;
		end
		return {lvl, o};
	endfunction

	// ==========================================================
	// Transmit path
	// ==========================================================
	phyx_pkg::phyx_nib_t nib_in; // Incoming MII nibble
	phyx_pkg::phyx_nib_t nib_buf; // Nibble at buffer head
	logic buf_valid; // Buffer holds a nibble
	logic take; // Output slot accepts one
	logic [4:0] enc_sym; // Coded symbol
	logic cipher_on; // Cipher in use
	logic line_nrzi; // NRZI applies
	logic [15:0] scr_res; // Scrambler result
	logic [4:0] scr_sym; // Symbol after cipher stage
	logic [5:0] nrzi_res; // NRZI result
	logic [4:0] line_sym; // Symbol as driven
	logic [10:0] tx_lfsr_reg; // Transmit keystream state
	logic tx_lvl_reg; // Last line level
	logic [4:0] tx_sym_reg; // Output symbol
	logic tx_sv_reg; // Output symbol valid

	assign nib_in = '{err: tx_er, nib: tx_nib};

	// Stall absorbs a receiver pause without losing a nibble
	phyx_buf2 u_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(nib_in),
		.out_valid(buf_valid),
		.out_ready(take),
		.out_data(nib_buf)
	);

	// Test translation only when both the bit and the error line agree
	phyx_enc45 u_enc (
		.nib_in(nib_buf),
		.inv_mode(inv_reg),
		.sym_out(enc_sym)
	);

	assign take = ~tx_sv_reg | tx_sym_ready;
	assign cipher_on = rate_100 & ~cdis_reg;
	assign line_nrzi = rate_100 & nrzi_reg;
	assign scr_res = scramble(tx_lfsr_reg, enc_sym);
	assign scr_sym = cipher_on ? scr_res[4:0] : enc_sym;
	assign nrzi_res = nrzi_code(tx_lvl_reg, scr_sym);
	assign line_sym = line_nrzi ? nrzi_res[4:0] : scr_sym;
	assign tx_sym = tx_sym_reg;
	assign tx_sym_valid = tx_sv_reg;

	// Output slot; keystream advances only with a sent symbol
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tx_lfsr_reg <= phyx_pkg::LFSR_SEED;
			tx_lvl_reg <= 1'h0;
			tx_sym_reg <= phyx_pkg::SYM_RST;
			tx_sv_reg <= 1'h0;
		end else if (take) begin
			tx_sv_reg <= buf_valid;
			if (buf_valid) begin
				tx_sym_reg <= line_sym;
				tx_lfsr_reg <= cipher_on ? scr_res[15:5] : tx_lfsr_reg;
				tx_lvl_reg <= line_nrzi ? nrzi_res[5] : tx_lvl_reg;
			end
		end
	end

	// ==========================================================
	// Receive path
	// ==========================================================
	logic [10:0] rx_lfsr_reg; // Receive keystream state
	logic [4:0] match_reg; // Clean idle count
	logic lock_reg; // Descrambler locked
	logic [4:0] rx_sym_reg; // Output symbol
	logic rx_sv_reg; // Output valid
	logic [16:0] dsc_res; // Descrambler result
	logic rx_cipher_on; // Receive cipher in use
	logic force_unlock; // Lock must drop

	assign rx_cipher_on = rate_100 & ~cdis_reg;
	// Test mode holds the descrambler out of lock so it must resync
	assign force_unlock = test_reg | ~rx_cipher_on;
	assign dsc_res = descramble(rx_lfsr_reg, rx_sym_in, ~lock_reg);
	assign rx_sym = rx_sym_reg;
	assign rx_sym_valid = rx_sv_reg;
	assign rx_locked = lock_reg;

	// Lock after a run of consistent idles, unscrambled when bypassed
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rx_lfsr_reg <= phyx_pkg::LFSR_SEED;
			match_reg <= 5'h00;
			lock_reg <= 1'h0;
			rx_sym_reg <= phyx_pkg::SYM_RST;
			rx_sv_reg <= 1'h0;
		end else begin
			rx_sv_reg <= rx_sym_in_valid;
			if (force_unlock) begin
				lock_reg <= 1'h0;
				match_reg <= 5'h00;
			end else if (rx_sym_in_valid & ~lock_reg) begin
				match_reg <= dsc_res[16] ? 5'h00 : match_reg + phyx_pkg::CNT_ONE;
				lock_reg <= ~dsc_res[16] & (match_reg + phyx_pkg::CNT_ONE == phyx_pkg::LOCK_MATCHES);
			end
			if (rx_sym_in_valid) begin
				rx_lfsr_reg <= dsc_res[15:5];
				// Unlocked or bypassed: pass raw symbols through
				rx_sym_reg <= (lock_reg & ~force_unlock) ? dsc_res[4:0] : rx_sym_in;
			end
		end
	end

endmodule // phyx_ext_ctrl

// >>> phyx_pkg.sv
// Shared constants and types of the extended control block
package phyx_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [4:0] EXT_CTRL_ADDR = 5'h10; // Extended control register

	// Field positions inside the extended control word
	localparam int OVR_BIT = 15; // Override-write enable, self clearing
	localparam int ADDR_HI = 10; // Management address, top bit
	localparam int ADDR_LO = 6; // Management address, bottom bit
	localparam int TEST_BIT = 5; // Scrambler test mode
	localparam int NRZI_BIT = 3; // Line encoding select
	localparam int INV_BIT = 2; // Invalid-code transmit test
	localparam int CDIS_BIT = 0; // Stream cipher disable

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic OVR_RST = 1'h0;
	localparam logic TEST_RST = 1'h0;
	localparam logic NRZI_RST = 1'h1;
	localparam logic INV_RST = 1'h0;
	localparam logic CDIS_RST = 1'h0;
	localparam logic [4:0] ADDR_RST = 5'h00; // Until the straps are caught
	localparam logic [15:0] RDATA_RST = 16'h0000;
	localparam logic [4:0] SYM_RST = 5'h00;

	// ==========================================================
	// Cipher constants
	// ==========================================================
	localparam logic [10:0] LFSR_SEED = 11'h7FF; // Any nonzero start
	localparam int LFSR_TAP_A = 10; // x^11 term
	localparam int LFSR_TAP_B = 8; // x^9 term
	localparam logic [4:0] LOCK_MATCHES = 5'h10; // Clean idle symbols for lock
	localparam logic [4:0] CNT_ONE = 5'h01;

	// ==========================================================
	// Buffer constants
	// ==========================================================
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	localparam logic [1:0] BUF_ONE = 2'h1;

	// ==========================================================
	// Types
	// ==========================================================
	// One MII transmit nibble with its error flag
	typedef struct packed {
		logic err;
		logic [3:0] nib;
	} phyx_nib_t;

	// Strap capture sequencing
	typedef enum logic {
		STRAP_WAIT,
		STRAP_DONE
	} phyx_strap_t;

endpackage

// >>> phyx_props.sv
// Concurrent checks on the extended control block ports
`timescale 1ns/1ps
module phyx_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic mgmt_wr_en,
	input wire logic mgmt_rd_en,
	input wire logic [4:0] mgmt_reg_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rdata_valid,
	input wire logic override_protected_bit_unlock,
	input wire logic [4:0] phy_addr,
	input wire logic rate_100,
	input wire logic tx_sym_valid,
	input wire logic tx_sym_ready,
	input wire logic [4:0] tx_sym,
	input wire logic rx_locked
);
	// ==========================================================
	// Shadow of the writable controls {test, nrzi, inv, cdis}
	// ==========================================================
	logic [3:0] ctl_reg; // Mirrors bits 5, 3, 2, 0
	logic [3:0] ctl_next; // Next shadow value
	logic [3:0] ctl_rst; // Defaults of those bits
	logic wr_hit; // Write aimed at this register
	assign ctl_rst = {phyx_pkg::TEST_RST, phyx_pkg::NRZI_RST, phyx_pkg::INV_RST, phyx_pkg::CDIS_RST};
	assign wr_hit = mgmt_wr_en && (mgmt_reg_addr == phyx_pkg::EXT_CTRL_ADDR);
	// Soft reset wins over a write in the same cycle
	assign ctl_next = soft_reset ? ctl_rst :
		(wr_hit ? {mgmt_wdata[5], mgmt_wdata[3:2], mgmt_wdata[0]} : ctl_reg);
	// Same asynchronous reset as the design, so the shadow never lags
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctl_reg <= ctl_rst;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// ==========================================================
	// Properties
	// ==========================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_rd_answer: assert property (mgmt_rd_en
		&& mgmt_reg_addr == phyx_pkg::EXT_CTRL_ADDR |=> mgmt_rdata_valid)
		else $error("read of control word not answered");
	chk_rsvd_zero: assert property (mgmt_rdata_valid
		|-> (mgmt_rdata & 16'h7812) == 16'h0000) else $error("reserved bits read nonzero");
	chk_rd_addr: assert property (mgmt_rdata_valid
		|-> mgmt_rdata[10:6] == phy_addr) else $error("address field differs from port");
	// Two edges of grace: the straps land on the first edge after release
	chk_addr_kept: assert property (!$past(reset, 2) |-> $stable(phy_addr))
		else $error("management address changed outside reset");
	chk_ctl_hold: assert property (mgmt_rdata_valid
		|-> {mgmt_rdata[5], mgmt_rdata[3:2], mgmt_rdata[0]} == $past(ctl_reg))
		else $error("control bits lost their written value");
	chk_unlock_set: assert property (wr_hit && mgmt_wdata[15] && !soft_reset
		|=> override_protected_bit_unlock) else $error("override enable not set");
	chk_unlock_clear: assert property (mgmt_wr_en && !(wr_hit && mgmt_wdata[15])
		|=> !override_protected_bit_unlock) else $error("override enable not self cleared");
	chk_lock_test: assert property (ctl_reg[3] [*3] |-> !rx_locked)
		else $error("lock held in scrambler test mode");
	chk_lock_rate: assert property (!rate_100 [*2] |-> !rx_locked)
		else $error("lock held at 10 megabit");
	chk_tx_hold: assert property (tx_sym_valid && !tx_sym_ready
		|=> tx_sym_valid && $stable(tx_sym)) else $error("stalled symbol not held");

	cover property ($rose(override_protected_bit_unlock));
	cover property (tx_sym_valid && !tx_sym_ready [*2]);
	cover property (mgmt_rdata_valid && mgmt_rdata[5]);
	cover property ($rose(rx_locked));
endmodule // phyx_props

bind phyx_ext_ctrl phyx_props u_props (.clk_sys, .reset, .soft_reset, .mgmt_wr_en, .mgmt_rd_en,
	.mgmt_reg_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rdata_valid, .override_protected_bit_unlock,
	.phy_addr, .rate_100, .tx_sym_valid, .tx_sym_ready, .tx_sym, .rx_locked);

// >>> phyx_sta_model.sv
// Station management entity model driving the register port
`timescale 1ns/1ps
module phyx_sta_model (
	input wire logic clk_sys,
	output logic mgmt_wr_en,
	output logic mgmt_rd_en,
	output logic [4:0] mgmt_reg_addr,
	output logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rdata_valid
);
	localparam logic [15:0] RSVD_MASK = 16'h7812; // Reserved places, default zero
	// Idle bus at time zero
	initial begin
		mgmt_wr_en = 1'h0;
		mgmt_rd_en = 1'h0;
		mgmt_reg_addr = 5'h1F;
		mgmt_wdata = 16'hFFFF;
	end
	// Released lines show the inverse, so stale values cannot pass
	task automatic release_bus();
		mgmt_reg_addr = ~mgmt_reg_addr;
		mgmt_wdata = ~mgmt_wdata;
	endtask
	// One write, taken at the rising edge in the middle
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		mgmt_wr_en = 1'h1;
		mgmt_reg_addr = a;
		mgmt_wdata = (a == phyx_pkg::EXT_CTRL_ADDR) ? (d & ~RSVD_MASK) : d;
		@(negedge clk_sys);
		mgmt_wr_en = 1'h0;
		release_bus();
	endtask
	// One read; the answer is sampled half a cycle after the taking edge
	task automatic rd(input logic [4:0] a, output logic v, output logic [15:0] d);
		@(negedge clk_sys);
		mgmt_rd_en = 1'h1;
		mgmt_reg_addr = a;
		@(negedge clk_sys);
		mgmt_rd_en = 1'h0;
		release_bus();
		v = mgmt_rdata_valid;
		d = mgmt_rdata;
	endtask
	// Arm the override, then the protected write
	task automatic prot_wr(input logic [4:0] a, input logic [15:0] d, input logic [15:0] ctl);
		wr(phyx_pkg::EXT_CTRL_ADDR, ctl | 16'h8000);
		wr(a, d);
	endtask
endmodule // phyx_sta_model

// >>> tb_phy_extended_control.sv
// Self-checking bench for the extended control block
`timescale 1ns/1ps
module tb_phy_extended_control;
	localparam logic [4:0] EXT = phyx_pkg::EXT_CTRL_ADDR;
	// Normal code table, then invalid-code test table
	localparam logic [4:0] SYM_TBL [32] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h00, 5'h01, 5'h02,
		5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
	logic clk_sys = 1'h0, reset = 1'h1, soft_reset = 1'h0, rate_100 = 1'h0;
	logic [4:0] strap = 5'h15; // Strap pattern
	logic tx_valid = 1'h0, tx_er = 1'h0, tx_sym_ready = 1'h0, rx_sym_in_valid = 1'h0;
	logic [3:0] tx_nib = 4'h0;
	logic [4:0] rx_sym_in = 5'h00;
	logic mgmt_wr_en, mgmt_rd_en, mgmt_rdata_valid, unlock, tx_ready, tx_sym_valid;
	logic rx_sym_valid, rx_locked, v;
	logic [4:0] mgmt_reg_addr, phy_addr, tx_sym, rx_sym;
	logic [15:0] mgmt_wdata, mgmt_rdata, d;
	int num_errors = 0, n_tests = 0, cyc = 0, acc, t;

	// ==========================================================
	// Clock, partner and design
	// ==========================================================
	always #4 clk_sys = ~clk_sys;
	phyx_sta_model sta (.clk_sys(clk_sys), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
		.mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rdata_valid(mgmt_rdata_valid));
	phyx_ext_ctrl dut (.clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
		.addr4_strap_pin(strap[4]), .addr3_strap_pin(strap[3]), .addr2_strap_pin(strap[2]),
		.addr1_strap_pin(strap[1]), .addr0_strap_pin(strap[0]), .mgmt_wr_en(mgmt_wr_en),
		.mgmt_rd_en(mgmt_rd_en), .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .mgmt_rdata_valid(mgmt_rdata_valid),
		.override_protected_bit_unlock(unlock), .phy_addr(phy_addr), .rate_100(rate_100),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_nib(tx_nib), .tx_er(tx_er),
		.tx_sym_valid(tx_sym_valid), .tx_sym_ready(tx_sym_ready), .tx_sym(tx_sym),
		.rx_sym_in_valid(rx_sym_in_valid), .rx_sym_in(rx_sym_in), .rx_sym_valid(rx_sym_valid),
		.rx_sym(rx_sym), .rx_locked(rx_locked));

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Read the control word and compare it
	task automatic rd_chk(input logic [15:0] exp);
		sta.rd(EXT, v, d);
		chk("rd_valid", {15'h0000, v}, 16'h0001);
		chk("rd_word", d, exp);
	endtask
	// Offer one nibble and hold it until taken
	task automatic push(input logic [3:0] n, input logic e);
		@(negedge clk_sys);
		tx_valid = 1'h1;
		tx_nib = n;
		tx_er = e;
		for (t = 0; t < 8 && tx_ready !== 1'h1; t++) @(negedge clk_sys);
		@(negedge clk_sys);
		tx_valid = 1'h0;
		tx_nib = ~n;
	endtask
	// Accept one symbol, stalling a cycle before each
	task automatic take(input logic [4:0] exp);
		@(negedge clk_sys);
		tx_sym_ready = 1'h1;
		for (t = 0; t < 8 && tx_sym_valid !== 1'h1; t++) @(negedge clk_sys);
		chk("tx_sym_valid", {15'h0000, tx_sym_valid}, 16'h0001);
		chk("tx_sym", {11'h000, tx_sym}, {11'h000, exp});
		@(negedge clk_sys);
		tx_sym_ready = 1'h0;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (10) @(negedge clk_sys);
		reset = 1'h0;
		rd_chk(16'h0548);
		chk("phy_addr", {11'h000, phy_addr}, 16'h0015);
		// Row table at 10 megabit: index bit 4 selects test mode with error
		for (int i = 0; i < 32; i++) begin
			if (i == 0 || i == 16) sta.wr(EXT, i[4] ? 16'h000C : 16'h0008);
			push(i[3:0], i[4]);
			take(SYM_TBL[i]);
		end
		// Fill the buffer against a stalled receiver, then drain in order
		sta.wr(EXT, 16'h0008);
		acc = 0;
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_sys);
			tx_valid = 1'h1;
			tx_nib = acc[3:0];
			tx_er = 1'h0;
			if (tx_ready === 1'h1) acc++;
		end
		@(negedge clk_sys);
		tx_valid = 1'h0;
		chk("tx_ready_full", {15'h0000, tx_ready}, 16'h0000);
		// Output slot plus two buffer entries
		chk("fill_count", acc[15:0], 16'h0003);
		for (int j = 0; j < acc; j++) take(SYM_TBL[j]);
		// Override enable: set, survives a read, clears on the next write
		sta.wr(EXT, 16'h8009);
		chk("unlock_set", {15'h0000, unlock}, 16'h0001);
		rd_chk(16'h8549);
		sta.wr(5'h00, 16'h0000);
		rd_chk(16'h0549);
		sta.prot_wr(5'h00, 16'h0000, 16'h0009);
		chk("unlock_clr", {15'h0000, unlock}, 16'h0000);
		sta.rd(5'h11, v, d);
		chk("unmapped", {15'h0000, v}, 16'h0000);
		// Test mode at 100 megabit forces unlock and raw receive
		rate_100 = 1'h1;
		rx_sym_in_valid = 1'h1;
		rx_sym_in = 5'h1F;
		sta.wr(EXT, 16'h0028);
		repeat (20) @(negedge clk_sys);
		chk("lock_test", {15'h0000, rx_locked}, 16'h0000);
		chk("rx_raw", {11'h000, rx_sym}, 16'h001F);
		// Cipher off and NRZ at 100 megabit send the plain code
		sta.wr(EXT, 16'h0001);
		push(4'hF, 1'h0);
		take(SYM_TBL[15]);
		chk("rx_plain", {11'h000, rx_sym}, 16'h001F);
		// NRZI from line level 0: 11110 goes out as 10100
		sta.wr(EXT, 16'h0009);
		push(4'h0, 1'h0);
		take(5'h14);
		// Cipher on from its seed: keys 00000, 00001, 10000
		sta.wr(EXT, 16'h0000);
		for (int k = 0; k < 3; k++) push(4'h0, 1'h0);
		take(5'h1E);
		take(5'h1F);
		take(5'h0E);
		// Idle stream trains the descrambler, lock follows
		repeat (8) @(negedge clk_sys);
		chk("lock_idle", {15'h0000, rx_locked}, 16'h0001);
		chk("rx_valid", {15'h0000, rx_sym_valid}, 16'h0001);
		chk("rx_descr", {11'h000, rx_sym}, 16'h001F);
		// Soft reset restores controls but keeps the address
		strap = 5'h0A;
		@(negedge clk_sys);
		soft_reset = 1'h1;
		@(negedge clk_sys);
		soft_reset = 1'h0;
		rd_chk(16'h0548);
		// Hardware reset reloads the address from the straps
		reset = 1'h1;
		@(negedge clk_sys);
		reset = 1'h0;
		rd_chk(16'h0288);
		chk("phy_addr_new", {11'h000, phy_addr}, 16'h000A);
		close_out();
	end
endmodule // tb_phy_extended_control
